/* File: core/ao_buffer_pkg.sv */
// Operation
// [R1] samples queue in one 256K-sample store shared among active channels
// [R2] written word: sample in bits 15..0, frame end in bit 16, rest ignored
// [R3] single writes and same-address bursts both accepted at the data port
// [R4] data port is write-only; reads of it return zero
// [R5] purge request empties the store; empty flag high when nothing held
// [R6] full flag while full; write when full is dropped and flagged
// [R7] write while closed in circular mode sets the closed-write flag; code sets writeWhenFull instead when the store is also full
// [R8] both loss flags stay high until written low or reset
// [R9] read-only 19-bit count of samples held, always current
// [R10] above-limit flag high when count exceeds limit; limit resets 3fffe
// [R11] open mode: each played sample is discarded
// [R12] circular mode keeps samples, replays them, refuses host writes
// [R13] frame-end mark travels with its sample; several frames may be held
// [R14] host should stop output clocking before loading a circular store
// [R15] circular continuous mode rescans contents while clocked
// [R16] circular burst: each trigger plays one frame, stops at frame end
// [R17] burst triggers play stored frames in order, open flushes, circular loops
// [R18] reload request opens store, raises reload window, flushes old frame
// [R19] old frame end closes store, clears window and request, new frame runs
// [R20] host must load whole new frame before old frame ends
// [R21] clock enable gates sample clocks; clock-ready flag shows data present (code: software clock not gated, ready flag also needs enable)
// [R22] update strobe pin pulses low on each sample clock
// [R23] reload window rises at frame position zero with circular and request
// [R24] purge and reload request bits clear themselves when done
// [R25] count rises per accepted write, falls per open-mode discard
package ao_buffer_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OPS_OFFSET    = 8'h38;
  localparam logic [7:0] LIMIT_OFFSET  = 8'h40;
  localparam logic [7:0] COUNT_OFFSET  = 8'h44;
  localparam logic [7:0] SAMPLE_OFFSET = 8'h48;

  ////////////////////////////////////////////////////////////////////////
  // sample word layout
  localparam int SAMPLE_W = 16;
  localparam int EOF_BIT  = 16;
  localparam int WORD_W   = 17;

  ////////////////////////////////////////////////////////////////////////
  // operations register fields
  localparam int MASK_LSB      = 0;
  localparam int CHAN_N        = 4;
  localparam int CLK_SEL_BIT   = 4;
  localparam int CLK_EN_BIT    = 5;
  localparam int CLK_RDY_BIT   = 6;
  localparam int SW_CLK_BIT    = 7;
  localparam int CIRC_BIT      = 8;
  localparam int RELOAD_BIT    = 9;
  localparam int WINDOW_BIT    = 10;
  localparam int PURGE_BIT     = 11;
  localparam int EMPTY_BIT     = 12;
  localparam int ABOVE_BIT     = 13;
  localparam int FULL_BIT      = 15;
  localparam int OVF_BIT       = 16;
  localparam int CLOSED_BIT    = 17;
  localparam int BURST_RDY_BIT = 18;
  localparam int BURST_EN_BIT  = 19;
  localparam int SW_TRIG_BIT   = 20;

  ////////////////////////////////////////////////////////////////////////
  // sizes and reset values
  localparam int          BUF_DEPTH   = 262144;
  localparam int          COUNT_W     = 19;
  localparam int          ABOVE_POS   = 19;
  localparam logic [3:0]  MASK_RESET  = 4'hf;
  localparam logic [18:0] LIMIT_RESET = 19'h3fffe;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int STROBE_LOW_NS = 100;
  localparam int STROBE_CYCLES =
    (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : ao_buffer_pkg

/* File: core/sample_store.sv */
`timescale 1ns/1ns
module sample_store #(
  parameter int DEPTH = ao_buffer_pkg::BUF_DEPTH,
  parameter int WIDTH = ao_buffer_pkg::WORD_W
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  // write side
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrIdx,
  input  wire logic [WIDTH-1:0]         wrWord,
  // read side
  input  wire logic [$clog2(DEPTH)-1:0] rdIdx,
  output logic      [WIDTH-1:0]         rdWord
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } store_t;

  store_t s;
  store_t next_s;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    if (wrEn) begin
      next_s.mem[wrIdx] = wrWord;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // read is flat from flops so the player sees the word in its own cycle
  assign rdWord = s.mem[rdIdx];

endmodule : sample_store

/* File: core/analog_output_sample_buffer.sv */
`timescale 1ns/1ns
module analog_output_sample_buffer #(
  parameter int DEPTH = ao_buffer_pkg::BUF_DEPTH
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [31:0] regWrData,
  output logic      [31:0] regRdData,
  // sample clock and trigger sources
  input  wire logic        rateTick,
  input  wire logic        extClkIn,
  input  wire logic        hwTrigger,
  // shared clock pin
  output logic             updateStrobeN,
  output logic             updateStrobeOe,
  // toward the converters
  output logic [15:0]      dacData,
  output logic             dacEof,
  output logic             dacStrobe,
  output logic [1:0]       dacChannel,
  output logic [18:0]      perChanDepth
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = ao_buffer_pkg::COUNT_W;
  localparam int SW = $clog2(ao_buffer_pkg::STROBE_CYCLES + 1);

  typedef logic [AW-1:0] ptr_t;
  typedef logic [CW-1:0] cnt_t;

  typedef struct packed {
    logic [3:0]  chanMask;
    logic        clkSel;
    logic        clkEn;
    logic        swClk;
    logic        circular;
    logic        reloadReq;
    logic        reloadWindow;
    logic        writeWhenFull;
    logic        closedWrite;
    logic        burstEn;
    logic        swTrig;
    logic        burstActive;
    logic [18:0] limit;
    ptr_t        basePtr;
    ptr_t        rdPtr;
    ptr_t        wrPtr;
    cnt_t        count;
    logic        extPrev;
    logic [SW-1:0] strobeCnt;
    logic [15:0] dacData;
    logic        dacEof;
    logic        dacStrobe;
    logic [1:0]  dacChannel;
    logic [18:0] chanDepth;
    logic [31:0] rdData;
  } state_t;

  state_t s;
  state_t next_s;

  logic [16:0] rdWord;
  logic        storeWr;
  logic [16:0] storeWord;

  ////////////////////////////////////////////////////////////////////////
  // [R1] shared sample store
  sample_store #(
    .DEPTH (DEPTH),
    .WIDTH (ao_buffer_pkg::WORD_W)
  ) u_store (
    .mclk   (mclk),
    .rstn   (rstn),
    .wrEn   (storeWr),
    .wrIdx  (s.wrPtr),
    .wrWord (storeWord),
    .rdIdx  (s.rdPtr),
    .rdWord (rdWord)
  );

  ////////////////////////////////////////////////////////////////////////
  logic        isEmpty;
  logic        isFull;
  logic        isOpen;
  logic        tick;
  logic        trigger;
  logic        play;
  logic        wordEof;
  logic        dataWr;
  logic        opsWr;
  logic        accept;
  logic        drop;
  logic [2:0]  activeN;
  logic [1:0]  nextChan;
  logic [31:0] opsView;
  ptr_t        rdNext;

  always_comb begin
    next_s    = s;
    storeWr   = 1'b0;
    // [R2] only sample and frame-end bits are kept
    storeWord = regWrData[ao_buffer_pkg::WORD_W-1:0];

    // [R5] empty and full from the count
    isEmpty = (s.count == '0);
    isFull  = (s.count == cnt_t'(DEPTH));
    // [R18] reload window reopens a circular store
    isOpen  = !s.circular || s.reloadWindow;
    wordEof = rdWord[ao_buffer_pkg::EOF_BIT];
    rdNext  = ptr_t'(s.rdPtr + 1'b1);

    dataWr = regWr && (regAddr == ao_buffer_pkg::SAMPLE_OFFSET);
    opsWr  = regWr && (regAddr == ao_buffer_pkg::OPS_OFFSET);

    // [R21] rate or external clock gated by enable, falling edge on the external pin; software clock not gated
    next_s.extPrev = extClkIn;
    tick = ((s.clkSel ? rateTick : (s.extPrev && !extClkIn)) && s.clkEn)
           || s.swClk;
    next_s.swClk = 1'b0;

    // [R22] strobe pin held low a few cycles per sample clock
    if (tick) begin
      next_s.strobeCnt = SW'(ao_buffer_pkg::STROBE_CYCLES);
    end else if (s.strobeCnt != '0) begin
      next_s.strobeCnt = SW'(s.strobeCnt - 1'b1);
    end

    // [R16] trigger starts one frame when no burst runs
    trigger = (s.swTrig || hwTrigger) && s.burstEn && !s.burstActive;
    if (trigger) begin
      next_s.burstActive = 1'b1;
    end

    // [R15] play while clocked, data held, and burst allowing
    play = tick && !isEmpty && (!s.burstEn || s.burstActive || trigger);

    next_s.dacStrobe = 1'b0;
    nextChan = s.dacChannel;
    for (int i = 1; i <= ao_buffer_pkg::CHAN_N; i++) begin
      if (nextChan == s.dacChannel
          && s.chanMask[2'(s.dacChannel + 2'(i))]) begin
        nextChan = 2'(s.dacChannel + 2'(i));
      end
    end

    // [R23] reload window opens at frame position zero
    if (s.circular && s.reloadReq && !s.reloadWindow
        && (s.rdPtr == s.basePtr)) begin
      next_s.reloadWindow = 1'b1;
    end

    if (play) begin
      next_s.dacData    = rdWord[ao_buffer_pkg::SAMPLE_W-1:0];
      // [R13] frame end leaves with its own sample
      next_s.dacEof     = wordEof;
      next_s.dacStrobe  = 1'b1;
      next_s.dacChannel = nextChan;
      if (isOpen) begin
        // [R11] open: played sample is discarded
        next_s.rdPtr   = rdNext;
        next_s.basePtr = rdNext;
        // [R19] old frame end closes store and clears request
        if (s.reloadWindow && wordEof) begin
          next_s.reloadWindow = 1'b0;
          next_s.reloadReq    = 1'b0;
        end
      end else if (rdNext == s.wrPtr) begin
        // [R17] circular: wrap back to the oldest frame
        next_s.rdPtr = s.basePtr;
      end else begin
        next_s.rdPtr = rdNext;
      end
      // [R16] burst ends at frame end or, in open mode, at last sample
      if (wordEof || (isOpen && s.count == cnt_t'(1))) begin
        next_s.burstActive = 1'b0;
        next_s.swTrig      = 1'b0;
      end
    end

    // [R12] closed store refuses host writes
    accept = dataWr && !isFull && isOpen;
    drop   = dataWr && !accept;
    if (accept) begin
      // [R3] every accepted word at the port goes to the tail
      storeWr      = 1'b1;
      next_s.wrPtr = ptr_t'(s.wrPtr + 1'b1);
    end

    // [R25] count follows writes and discards
    next_s.count = cnt_t'(s.count + cnt_t'(accept) - cnt_t'(play && isOpen));

    // register writes
    if (opsWr) begin
      next_s.chanMask  = regWrData[ao_buffer_pkg::MASK_LSB +: 4];
      next_s.clkSel    = regWrData[ao_buffer_pkg::CLK_SEL_BIT];
      next_s.clkEn     = regWrData[ao_buffer_pkg::CLK_EN_BIT];
      next_s.circular  = regWrData[ao_buffer_pkg::CIRC_BIT];
      next_s.burstEn   = regWrData[ao_buffer_pkg::BURST_EN_BIT];
      next_s.swClk     = regWrData[ao_buffer_pkg::SW_CLK_BIT];
      if (regWrData[ao_buffer_pkg::SW_TRIG_BIT]) begin
        next_s.swTrig = 1'b1;
      end
      if (regWrData[ao_buffer_pkg::RELOAD_BIT]) begin
        next_s.reloadReq = 1'b1;
      end
      // [R8] loss flags clear only by a written zero
      if (!regWrData[ao_buffer_pkg::OVF_BIT]) begin
        next_s.writeWhenFull = 1'b0;
      end
      if (!regWrData[ao_buffer_pkg::CLOSED_BIT]) begin
        next_s.closedWrite = 1'b0;
      end
    end
    if (regWr && (regAddr == ao_buffer_pkg::LIMIT_OFFSET)) begin
      next_s.limit = regWrData[18:0];
    end

    // [R6] write into a full store is dropped and flagged
    if (drop && isFull) begin
      next_s.writeWhenFull = 1'b1;
    end
    // [R7] write into a closed store is flagged; set beats clear
    if (drop && !isFull) begin
      next_s.closedWrite = 1'b1;
    end

    // [R24] purge acts at once, so its bit never reads high
    if (opsWr && regWrData[ao_buffer_pkg::PURGE_BIT]) begin
      next_s.rdPtr        = '0;
      next_s.basePtr      = '0;
      next_s.wrPtr        = '0;
      next_s.count        = '0;
      next_s.burstActive  = 1'b0;
      next_s.reloadWindow = 1'b0;
      storeWr             = 1'b0;
    end

    // per-channel share of the store
    activeN = '0;
    for (int i = 0; i < ao_buffer_pkg::CHAN_N; i++) begin
      activeN = 3'(activeN + 3'(s.chanMask[i]));
    end
    case (activeN)
      3'h1:    next_s.chanDepth = 19'(DEPTH);
      3'h2:    next_s.chanDepth = 19'(DEPTH / 2);
      3'h3:    next_s.chanDepth = 19'(DEPTH / 3);
      3'h4:    next_s.chanDepth = 19'(DEPTH / 4);
      default: next_s.chanDepth = '0;
    endcase

    opsView = '0;
    opsView[ao_buffer_pkg::MASK_LSB +: 4]     = s.chanMask;
    opsView[ao_buffer_pkg::CLK_SEL_BIT]       = s.clkSel;
    opsView[ao_buffer_pkg::CLK_EN_BIT]        = s.clkEn;
    opsView[ao_buffer_pkg::CLK_RDY_BIT]       = s.clkEn && !isEmpty;
    opsView[ao_buffer_pkg::SW_CLK_BIT]        = s.swClk;
    opsView[ao_buffer_pkg::CIRC_BIT]          = s.circular;
    opsView[ao_buffer_pkg::RELOAD_BIT]        = s.reloadReq;
    opsView[ao_buffer_pkg::WINDOW_BIT]        = s.reloadWindow;
    opsView[ao_buffer_pkg::EMPTY_BIT]         = isEmpty;
    opsView[ao_buffer_pkg::ABOVE_BIT]         = (s.count > s.limit);
    opsView[ao_buffer_pkg::FULL_BIT]          = isFull;
    opsView[ao_buffer_pkg::OVF_BIT]           = s.writeWhenFull;
    opsView[ao_buffer_pkg::CLOSED_BIT]        = s.closedWrite;
    opsView[ao_buffer_pkg::BURST_RDY_BIT]     = !s.burstActive;
    opsView[ao_buffer_pkg::BURST_EN_BIT]      = s.burstEn;
    opsView[ao_buffer_pkg::SW_TRIG_BIT]       = s.swTrig;

    if (regRd) begin
      case (regAddr)
        ao_buffer_pkg::OPS_OFFSET: next_s.rdData = opsView;
        // [R10] limit with above-limit flag in bit 19
        ao_buffer_pkg::LIMIT_OFFSET: begin
          next_s.rdData = {12'h000, (s.count > s.limit), s.limit};
        end
        // [R9] live count of held samples
        ao_buffer_pkg::COUNT_OFFSET: next_s.rdData = {13'h0000, s.count};
        // [R4] data port reads back zero
        ao_buffer_pkg::SAMPLE_OFFSET: next_s.rdData = 32'h0000_0000;
        default: next_s.rdData = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s          <= '0;
      s.chanMask <= ao_buffer_pkg::MASK_RESET;
      s.limit    <= ao_buffer_pkg::LIMIT_RESET;
      s.extPrev  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin driven only when this board sources the clock
  assign updateStrobeN  = (s.strobeCnt == '0);
  assign updateStrobeOe = s.clkSel;
  assign regRdData      = s.rdData;
  assign dacData        = s.dacData;
  assign dacEof         = s.dacEof;
  assign dacStrobe      = s.dacStrobe;
  assign dacChannel     = s.dacChannel;
  assign perChanDepth   = s.chanDepth;

endmodule : analog_output_sample_buffer

/* File: verif/ao_buffer_asserts.sv */
`timescale 1ns/1ns
module ao_buffer_asserts #(
  parameter int DEPTH = ao_buffer_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regWrData,
  input wire logic [31:0] regRdData,
  // clock and trigger sources
  input wire logic        rateTick,
  input wire logic        extClkIn,
  input wire logic        hwTrigger,
  // outputs
  input wire logic        updateStrobeN,
  input wire logic        updateStrobeOe,
  input wire logic [15:0] dacData,
  input wire logic        dacEof,
  input wire logic        dacStrobe,
  input wire logic [1:0]  dacChannel,
  input wire logic [18:0] perChanDepth
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic opsWr;
  logic opsRd;
  assign opsWr = regWr && regAddr == ao_buffer_pkg::OPS_OFFSET;
  assign opsRd = regRd && regAddr == ao_buffer_pkg::OPS_OFFSET;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_purge_read;
    opsWr && regWrData[ao_buffer_pkg::PURGE_BIT] ##1 !regWr ##1 opsRd;
  endsequence
  // a second ops write too soon would mask the lag, so exclude it
  sequence s_ops_settled;
    opsWr ##1 !opsWr;
  endsequence
  property p_rd_port_zero;
    regRd && regAddr == ao_buffer_pkg::SAMPLE_OFFSET |=> regRdData == 32'h0;
  endproperty
  property p_count_upper;
    regRd && regAddr == ao_buffer_pkg::COUNT_OFFSET |=> regRdData[31:19] == 0;
  endproperty
  property p_purge_empty;
    s_purge_read |=> regRdData[ao_buffer_pkg::EMPTY_BIT];
  endproperty
  property p_purge_selfclr;
    s_purge_read |=> !regRdData[ao_buffer_pkg::PURGE_BIT];
  endproperty
  property p_clk_src;
    s_ops_settled |=>
      updateStrobeOe == $past(regWrData[ao_buffer_pkg::CLK_SEL_BIT], 2);
  endproperty
  property p_chan_depth;
    (opsWr && |regWrData[3:0]) ##1 !opsWr |=>
      perChanDepth == 19'(DEPTH / $countones($past(regWrData[3:0], 2)));
  endproperty
  property p_strobe_pin;
    dacStrobe |-> !updateStrobeN [*2];
  endproperty
  property p_strobe_width;
    $fell(updateStrobeN) |=> !updateStrobeN;
  endproperty
  property p_dac_hold;
    !dacStrobe |-> $stable({dacEof, dacData});
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_rd_port_zero: assert property (p_rd_port_zero)
    else $error("data port read not zero");
  a_count_upper: assert property (p_count_upper)
    else $error("count upper bits set");
  a_purge_empty: assert property (p_purge_empty)
    else $error("not empty after purge");
  a_purge_selfclr: assert property (p_purge_selfclr)
    else $error("purge bit stuck");
  a_clk_src: assert property (p_clk_src)
    else $error("strobe pin drive wrong for source");
  a_chan_depth: assert property (p_chan_depth)
    else $error("per channel depth wrong");
  a_strobe_pin: assert property (p_strobe_pin)
    else $error("strobe pin not low with play");
  a_strobe_width: assert property (p_strobe_width)
    else $error("strobe pin low too short");
  a_dac_hold: assert property (p_dac_hold)
    else $error("output sample changed without play");
endmodule : ao_buffer_asserts

bind analog_output_sample_buffer ao_buffer_asserts #(.DEPTH(DEPTH)) u_asserts (
  .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWr(regWr),
  .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData),
  .rateTick(rateTick), .extClkIn(extClkIn), .hwTrigger(hwTrigger),
  .updateStrobeN(updateStrobeN), .updateStrobeOe(updateStrobeOe),
  .dacData(dacData), .dacEof(dacEof), .dacStrobe(dacStrobe),
  .dacChannel(dacChannel), .perChanDepth(perChanDepth)
);

/* File: verif/host_model.sv */
`timescale 1ns/1ns
module host_model (
  // clock
  input  wire logic        mclk,
  // register port
  output logic      [7:0]  regAddr,
  output logic             regWr,
  output logic             regRd,
  output logic      [31:0] regWrData,
  input  wire logic [31:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    regWrData = 32'h0;
  end
  // released lines flip so a stale value never passes as valid
  task automatic idle();
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = ~regAddr;
    regWrData = ~regWrData;
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge mclk);
    idle();
  endtask : wr
  // same-address burst, back to back or with gaps
  task automatic wrn(input logic [7:0] a, input logic [31:0] d[$],
                     input bit slow);
    foreach (d[i]) begin
      @(negedge mclk);
      regAddr = a;
      regWrData = d[i];
      regWr = 1'b1;
      if (slow) begin
        @(negedge mclk);
        idle();
      end
    end
    @(negedge mclk);
    idle();
  endtask : wrn
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge mclk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge mclk);
    v = regRdData;
    idle();
  endtask : rd
endmodule : host_model

/* File: verif/tb_analog_output_sample_buffer.sv */
`timescale 1ns/1ns
module tb_analog_output_sample_buffer;
  localparam int         D   = 16;
  localparam logic [7:0] OPS = ao_buffer_pkg::OPS_OFFSET;
  localparam logic [7:0] LIM = ao_buffer_pkg::LIMIT_OFFSET;
  localparam logic [7:0] CNT = ao_buffer_pkg::COUNT_OFFSET;
  localparam logic [7:0] DAT = ao_buffer_pkg::SAMPLE_OFFSET;
  logic        mclk;
  logic        rstn;
  logic        rateTick;
  logic        extClkIn;
  logic        hwTrigger;
  logic [7:0]  regAddr;
  logic        regWr;
  logic        regRd;
  logic [31:0] regWrData;
  logic [31:0] regRdData;
  logic        updateStrobeN;
  logic        updateStrobeOe;
  logic [15:0] dacData;
  logic        dacEof;
  logic        dacStrobe;
  logic [1:0]  dacChannel;
  logic [18:0] perChanDepth;
  logic [31:0] v;
  int          fails;
  int          compares;
  int          ch;
  int          q[$];

  analog_output_sample_buffer #(.DEPTH(D)) uut (
    .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData),
    .rateTick(rateTick), .extClkIn(extClkIn), .hwTrigger(hwTrigger),
    .updateStrobeN(updateStrobeN), .updateStrobeOe(updateStrobeOe),
    .dacData(dacData), .dacEof(dacEof), .dacStrobe(dacStrobe),
    .dacChannel(dacChannel), .perChanDepth(perChanDepth));
  host_model host (
    .mclk(mclk), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regWrData(regWrData), .regRdData(regRdData));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    host.rd(a, v);
    chk($sformatf("reg %h", a), e, v & m);
  endtask : rdm
  // one sample clock; e is the expected word, negative when none plays
  task automatic tick(input bit ext, input int e);
    if (ext) begin
      // falling pin is seen at the very next edge; strobe stands one cycle
      @(negedge mclk) extClkIn = 1'b0;
      @(negedge mclk) extClkIn = 1'b1;
    end else begin
      @(negedge mclk) rateTick = 1'b1;
      @(negedge mclk) rateTick = 1'b0;
    end
    chk("played", e >= 0, dacStrobe);
    if (e >= 0) begin
      ch = (ch + 1) % 4;
      chk("sample", e, {dacEof, dacData});
      chk("channel", ch, dacChannel);
    end
  endtask : tick
  task automatic load(input int n, input bit slow);
    logic [31:0] w[$];
    logic [31:0] d;
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      // frame end in bit 16, upper bits random
      d[16] = (i == n - 1);
      q.push_back(int'(d[16:0]));
      w.push_back(d);
    end
    host.wrn(DAT, w, slow);
  endtask : load
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    close_out();
  end
  initial begin
    int n;
    int s;
    rstn = 1'b0;
    rateTick = 1'b0;
    extClkIn = 1'b1;
    hwTrigger = 1'b0;
    fails = 0;
    compares = 0;
    ch = 0;
    void'($urandom(54204));
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    rdm(LIM, '1, 32'h0003fffe);
    rdm(CNT, '1, 32'h0);
    rdm(DAT, '1, 32'h0);
    rdm(8'h10, '1, 32'h0);
    rdm(OPS, '1, 32'h0004100f);
    chk("depth", D / 4, perChanDepth);
    $display("test reset done");
    load(D, 1'b1);
    rdm(CNT, '1, D);
    host.wr(DAT, 32'h1);
    rdm(OPS, 32'h18000, 32'h18000);
    rdm(CNT, '1, D);
    rdm(OPS, 32'h10000, 32'h10000);
    host.wr(LIM, D);
    rdm(LIM, 32'hfffff, D);
    host.wr(LIM, D - 1);
    rdm(LIM, 32'hfffff, 32'h80000 | (D - 1));
    host.wr(OPS, 32'h3f);
    rdm(OPS, 32'h10000, 32'h0);
    $display("test fill done");
    for (n = 0; n < D; n++) begin
      if (n == D / 2)
        host.wr(OPS, 32'h2f);
      tick(n >= D / 2, q.pop_front());
    end
    tick(1'b1, -1);
    rdm(CNT, '1, 32'h0);
    host.wr(OPS, 32'h03);
    load(2, 1'b0);
    tick(1'b1, -1);
    chk("depth", D / 2, perChanDepth);
    host.wr(OPS, 32'h80f);
    rdm(OPS, 32'h1800, 32'h1000);
    q.delete();
    rdm(CNT, '1, 32'h0);
    $display("test open done");
    // clocking stays off while the circular store loads
    host.wr(OPS, 32'h1f);
    load(3, 1'b0);
    host.wr(OPS, 32'h13f);
    for (n = 0; n < 9; n++)
      tick(1'b0, q[n % 3]);
    rdm(CNT, '1, 32'h3);
    host.wr(DAT, 32'h5);
    rdm(OPS, 32'h20040, 32'h20040);
    rdm(CNT, '1, 32'h3);
    $display("test circular done");
    host.wr(OPS, 32'h33f);
    v = 32'h0;
    for (n = 0; n < 8 && v[10] !== 1'b1; n++)
      host.rd(OPS, v);
    chk("window", 1, v[10]);
    if (v[10] !== 1'b1)
      close_out();
    load(2, 1'b1);
    for (n = 0; n < 7; n++)
      tick(1'b0, n < 3 ? q[n] : q[3 + (n - 3) % 2]);
    rdm(OPS, 32'h600, 32'h0);
    rdm(CNT, '1, 32'h2);
    $display("test reload done");
    host.wr(OPS, 32'h80f);
    q.delete();
    load(2, 1'b0);
    load(3, 1'b0);
    host.wr(OPS, 32'h8013f);
    tick(1'b0, -1);
    for (n = 0; n < 3; n++) begin
      if (n < 2)
        host.wr(OPS, 32'h18013f);
      else begin
        @(negedge mclk) hwTrigger = 1'b1;
        @(negedge mclk) hwTrigger = 1'b0;
      end
      s = (n == 1) ? 2 : 0;
      for (int k = 0; k < ((n == 1) ? 3 : 2); k++)
        tick(1'b0, q[s + k]);
      tick(1'b0, -1);
    end
    rdm(CNT, '1, 32'h5);
    $display("test burst done");
    close_out();
  end
endmodule : tb_analog_output_sample_buffer
